// ### dsc_pkg.sv
// Purpose: Shared constants for the strobe-cycle DRAM controller
// Assumes: 10 MHz core clock, faster speed grade selected at build time
// Notes: Times are kept in ns (or us/ms), cycle counts derived from them
`default_nettype none
package dsc_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int ADDR_W = 16;
    localparam int ROW_W = 8;
    localparam int ROW_COUNT = 256;
    localparam int INIT_CYCLES = 8;
    // Faster grade figures
    localparam int RAS_PULSE_NS = 100;
    localparam int RAS_PRECHARGE_NS = 50;
    localparam int RANDOM_CYCLE_PERIOD_NS = 160;
    localparam int ROW_TO_COLUMN_STROBE_DELAY_NS = 30;
    localparam int COLUMN_ADDRESS_HOLD_FROM_ROW_NS = 40;
    localparam int ROW_STROBE_ACCESS_TIME_NS = 100;
    localparam int COLUMN_ADDRESS_ACCESS_TIME_NS = 55;
    localparam int COLUMN_STROBE_ACCESS_TIME_NS = 20;
    localparam int WRITE_LEAD_TO_ROW_STROBE_RISE_NS = 30;
    localparam int WRITE_STROBE_PULSE_WIDTH_NS = 20;
    localparam int WRITE_RAS_HOLD_NS = 35;
    localparam int READ_HOLD_AFTER_ROW_STROBE_NS = 10;
    localparam int OUTPUT_FLOAT_DELAY_NS = 20;
    localparam int POWER_UP_PAUSE_US = 100;
    localparam int REFRESH_INTERVAL_LIMIT_MS = 4;
    localparam int EXT_REFRESH_INTERVAL_LIMIT_MS = 64;

    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    function automatic int floor_cyc(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Whole cycle counts; access and float times are longest, so floor is unsafe for sampling
    localparam int RAS_ACTIVE_CYC = ceil_cyc(RAS_PULSE_NS);
    localparam int RAS_PRECHARGE_CYC = ceil_cyc(RAS_PRECHARGE_NS);
    localparam int CYCLE_CYC = ceil_cyc(RANDOM_CYCLE_PERIOD_NS);
    localparam int RCD_CYC = ceil_cyc(ROW_TO_COLUMN_STROBE_DELAY_NS);
    localparam int AR_CYC = ceil_cyc(COLUMN_ADDRESS_HOLD_FROM_ROW_NS);
    localparam int RAC_CYC = ceil_cyc(ROW_STROBE_ACCESS_TIME_NS);
    localparam int CAA_CYC = ceil_cyc(COLUMN_ADDRESS_ACCESS_TIME_NS);
    localparam int CAC_CYC = ceil_cyc(COLUMN_STROBE_ACCESS_TIME_NS);
    localparam int WP_CYC = ceil_cyc(WRITE_STROBE_PULSE_WIDTH_NS);
    localparam int RWL_CYC = ceil_cyc(WRITE_LEAD_TO_ROW_STROBE_RISE_NS);
    localparam int RSHW_CYC = ceil_cyc(WRITE_RAS_HOLD_NS);
    localparam int RRH_CYC = ceil_cyc(READ_HOLD_AFTER_ROW_STROBE_NS);
    localparam int OFF_CYC = ceil_cyc(OUTPUT_FLOAT_DELAY_NS);
    localparam int PAUSE_CYC = ceil_cyc(POWER_UP_PAUSE_US * 1000);
    // Refresh period per row: limit / rows, rounded down
    localparam int REFRESH_SPACING_CYC = floor_cyc(REFRESH_INTERVAL_LIMIT_MS * 1000000 / ROW_COUNT);
    localparam int EXT_REFRESH_SPACING_CYC = floor_cyc(EXT_REFRESH_INTERVAL_LIMIT_MS * 1000000 / ROW_COUNT);
    localparam int IDLE_LIMIT_CYC = floor_cyc(EXT_REFRESH_INTERVAL_LIMIT_MS * 1000000);

    typedef enum logic [1:0] {
        DSC_CMD_READ = 2'b00,
        DSC_CMD_WRITE = 2'b01,
        DSC_CMD_RMW = 2'b10,
        DSC_CMD_REFRESH = 2'b11
    } dsc_cmd_e;
endpackage
`default_nettype wire

// ### dsc_seq_if.sv
// Purpose: Carries one strobe-cycle request from scheduler to sequencer
// Assumes: Single clock domain
// Notes: start is a one-cycle pulse accepted only while busy is low
`default_nettype none
interface dsc_seq_if;
    logic start;
    dsc_pkg::dsc_cmd_e cmd;
    logic [dsc_pkg::ROW_W-1:0] row;
    logic [dsc_pkg::ROW_W-1:0] col;
    logic wdata;
    logic busy;
    logic done;
    logic rdata;
    modport master (output start, output cmd, output row, output col, output wdata,
                    input busy, input done, input rdata);
    modport slave (input start, input cmd, input row, input col, input wdata,
                   output busy, output done, output rdata);
endinterface
`default_nettype wire

// ### dsc_seq.sv
// Purpose: Generates one row/column strobe cycle on the memory pins
// Assumes: Pin inputs already synchronised by the caller
// Notes: All strobe and address outputs are registered
`default_nettype none
module dsc_seq (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    dsc_seq_if.slave seq,
    input wire logic dout_sync_in,
    output logic ras_n_out,
    output logic cas_n_out,
    output logic we_n_out,
    output logic [dsc_pkg::ROW_W-1:0] addr_out,
    output logic din_out
);
    import dsc_pkg::*;
    localparam int CW = 8;
    localparam logic [CW-1:0] T_CAS = CW'(RCD_CYC);
    // Data pin passes two flops in the caller before it reaches this module
    localparam int SYNC_CYC = 2;
    localparam logic [CW-1:0] T_SAMPLE = CW'(RCD_CYC + ((CAA_CYC > CAC_CYC) ? CAA_CYC : CAC_CYC) + SYNC_CYC);
    localparam logic [CW-1:0] T_RAC = CW'(RAC_CYC);
    localparam logic [CW-1:0] T_WE = CW'(T_SAMPLE + 1);
    localparam logic [CW-1:0] T_RAS_UP_RD = CW'(RAS_ACTIVE_CYC > T_SAMPLE + 1 ? RAS_ACTIVE_CYC : T_SAMPLE + 1);
    localparam logic [CW-1:0] T_RAS_UP_WR = CW'(RAS_ACTIVE_CYC > RCD_CYC + RSHW_CYC + WP_CYC ?
                                               RAS_ACTIVE_CYC : RCD_CYC + RSHW_CYC + WP_CYC);
    localparam logic [CW-1:0] T_RAS_UP_RMW = CW'(T_WE + (WP_CYC > RWL_CYC ? WP_CYC : RWL_CYC));
    localparam logic [CW-1:0] T_END_PAD = CW'(RAS_PRECHARGE_CYC > OFF_CYC ? RAS_PRECHARGE_CYC : OFF_CYC);
    typedef enum logic [1:0] {
        DSC_S_IDLE = 2'b00,
        DSC_S_ACTIVE = 2'b01,
        DSC_S_PRECH = 2'b10
    } dsc_seq_state_e;
    dsc_seq_state_e state_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] ras_up_r;
    dsc_cmd_e cmd_r;
    logic [ROW_W-1:0] col_r;
    logic rdata_r;
    logic done_r;

    function automatic logic [CW-1:0] ras_len(input dsc_cmd_e c);
        case (c)
            DSC_CMD_WRITE: ras_len = T_RAS_UP_WR;
            DSC_CMD_RMW: ras_len = T_RAS_UP_RMW;
            default: ras_len = T_RAS_UP_RD;
        endcase
    endfunction

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= DSC_S_IDLE;
            cnt_r <= '0;
            ras_up_r <= '0;
            cmd_r <= DSC_CMD_READ;
            col_r <= '0;
            ras_n_out <= 1'b1;
            cas_n_out <= 1'b1;
            we_n_out <= 1'b1;
            addr_out <= '0;
            din_out <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                DSC_S_IDLE: begin
                    if (seq.start) begin
                        state_r <= DSC_S_ACTIVE;
                        cnt_r <= CW'(1);
                        ras_up_r <= ras_len(seq.cmd);
                        cmd_r <= seq.cmd;
                        col_r <= seq.col;
                        addr_out <= seq.row;
                        din_out <= seq.wdata;
                        ras_n_out <= 1'b0;
                        // Early write: strobe down before column strobe falls
                        we_n_out <= (seq.cmd == DSC_CMD_WRITE) ? 1'b0 : 1'b1;
                    end
                end
                DSC_S_ACTIVE: begin
                    cnt_r <= cnt_r + CW'(1);
                    if (cmd_r != DSC_CMD_REFRESH && cnt_r == T_CAS) begin
                        addr_out <= col_r;
                        cas_n_out <= 1'b0;
                    end
                    // Sample only once the synchroniser carries the accessed bit
                    if (cmd_r != DSC_CMD_REFRESH && cnt_r == T_SAMPLE && cnt_r >= T_RAC) begin
                        rdata_r <= dout_sync_in;
                    end
                    if (cmd_r == DSC_CMD_RMW && cnt_r == T_WE) begin
                        we_n_out <= 1'b0;
                    end
                    if (cnt_r == ras_up_r) begin
                        ras_n_out <= 1'b1;
                        cas_n_out <= 1'b1;
                        // Write strobe rises with the strobes, keeping read hold
                        we_n_out <= 1'b1;
                        state_r <= DSC_S_PRECH;
                        cnt_r <= CW'(1);
                    end
                end
                DSC_S_PRECH: begin
                    cnt_r <= cnt_r + CW'(1);
                    // Cycle period and output float both covered before next start
                    if (cnt_r >= T_END_PAD && (ras_up_r + cnt_r) >= CW'(CYCLE_CYC)) begin
                        state_r <= DSC_S_IDLE;
                        done_r <= 1'b1;
                    end
                end
                default: state_r <= DSC_S_IDLE;
            endcase
        end
    end

    assign seq.busy = (state_r != DSC_S_IDLE);
    assign seq.done = done_r;
    assign seq.rdata = rdata_r;
endmodule
`default_nettype wire

// ### dsc_ctrl.sv
// What this block does
// - Wait power-up pause, then eight row strobe cycles before any access.
// - After over 64 ms without strobes, issue eight initialization cycles again.
// - Refresh each row within 4 ms; 64 ms when only row-only refresh used.
// - Space row strobe falling edges by at least the random cycle period.
// - Write strobe low by column strobe fall gives early write, output floats.
// - Write strobe late after all three references gives read-modify-write.
// - Read: write strobe high until column strobe rises or 10 ns after row.
// - Read: write strobe high no later than column strobe falling edge.
// - Write strobe low at least 30 ns before row and column strobes rise.
// - Write strobe held low at least 20 ns during a write.
// - Row strobe stays low at least 35 ns after column strobe falls.
// - Column address valid until at least 40 ns after row strobe falls.
// - Split 16-bit address into 8-bit row and 8-bit column parts.
// - Full refresh: row strobe on all 256 rows; any cycle refreshes its row.
//
// Purpose: Host-side controller driving a 64K x 1 strobe-multiplexed dynamic RAM
// Assumes: 10 MHz core clock; memory data output arrives asynchronously
// Notes: Requests from user logic are taken while ready_out is high
`default_nettype none
module dsc_ctrl #(
    parameter int PAUSE_CYCLES = dsc_pkg::PAUSE_CYC,
    parameter int REFRESH_SPACING = dsc_pkg::REFRESH_SPACING_CYC,
    parameter int EXT_REFRESH_SPACING = dsc_pkg::EXT_REFRESH_SPACING_CYC,
    parameter int IDLE_LIMIT = dsc_pkg::IDLE_LIMIT_CYC
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic req_valid_in,
    input wire dsc_pkg::dsc_cmd_e req_cmd_in,
    input wire logic [dsc_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic req_wdata_in,
    input wire logic low_power_in,
    output logic ready_out,
    output logic resp_valid_out,
    output logic resp_rdata_out,
    output logic init_done_out,
    output logic ras_n_out,
    output logic cas_n_out,
    output logic we_n_out,
    output logic [dsc_pkg::ROW_W-1:0] addr_out,
    output logic din_out,
    input wire logic dout_in
);
    import dsc_pkg::*;
    localparam int TW = 32;
    localparam logic [3:0] INIT_N = 4'(INIT_CYCLES);
    // Early request covers a user cycle in flight plus issue latency
    localparam int REFRESH_SLACK = 16;

    typedef enum logic [2:0] {
        DSC_M_PAUSE = 3'b000,
        DSC_M_INIT = 3'b001,
        DSC_M_IDLE = 3'b010,
        DSC_M_BUSY = 3'b011,
        DSC_M_WAIT = 3'b100
    } dsc_main_state_e;

    dsc_main_state_e state_r;
    logic [TW-1:0] timer_r;
    logic [TW-1:0] refresh_timer_r;
    logic [TW-1:0] idle_timer_r;
    logic [3:0] init_cnt_r;
    logic [ROW_W-1:0] refresh_row_r;
    logic refresh_due_r;
    logic is_user_r;
    logic dout_meta_r;
    logic dout_sync_r;
    logic low_power_meta_r;
    logic low_power_sync_r;
    logic start_r;
    dsc_cmd_e cmd_r;
    logic [ROW_W-1:0] row_r;
    logic [ROW_W-1:0] col_r;
    logic wdata_r;
    logic [TW-1:0] spacing;

    dsc_seq_if seq_bus ();

    dsc_seq u_seq (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .seq(seq_bus.slave),
        .dout_sync_in(dout_sync_r),
        .ras_n_out(ras_n_out),
        .cas_n_out(cas_n_out),
        .we_n_out(we_n_out),
        .addr_out(addr_out),
        .din_out(din_out)
    );

    assign seq_bus.start = start_r;
    assign seq_bus.cmd = cmd_r;
    assign seq_bus.row = row_r;
    assign seq_bus.col = col_r;
    assign seq_bus.wdata = wdata_r;

    // Pin inputs pass two flops before use
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dout_meta_r <= 1'b0;
            dout_sync_r <= 1'b0;
            low_power_meta_r <= 1'b0;
            low_power_sync_r <= 1'b0;
        end else begin
            dout_meta_r <= dout_in;
            dout_sync_r <= dout_meta_r;
            low_power_meta_r <= low_power_in;
            low_power_sync_r <= low_power_meta_r;
        end
    end

    // Extended spacing only while user accesses are blocked
    assign spacing = low_power_sync_r ? TW'(EXT_REFRESH_SPACING) : TW'(REFRESH_SPACING);

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            refresh_timer_r <= '0;
            refresh_due_r <= 1'b0;
        end else if (state_r == DSC_M_BUSY && !is_user_r) begin
            refresh_timer_r <= '0;
            refresh_due_r <= 1'b0;
        end else if (refresh_timer_r >= spacing - TW'(REFRESH_SLACK)) begin
            refresh_due_r <= 1'b1;
        end else begin
            refresh_timer_r <= refresh_timer_r + TW'(1);
        end
    end

    // Strobe inactivity watchdog; every cycle start, refresh or user, clears it
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            idle_timer_r <= '0;
        end else if (start_r) begin
            idle_timer_r <= '0;
        end else if (idle_timer_r < TW'(IDLE_LIMIT)) begin
            idle_timer_r <= idle_timer_r + TW'(1);
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= DSC_M_PAUSE;
            timer_r <= '0;
            init_cnt_r <= '0;
            refresh_row_r <= '0;
            is_user_r <= 1'b0;
            start_r <= 1'b0;
            cmd_r <= DSC_CMD_REFRESH;
            row_r <= '0;
            col_r <= '0;
            wdata_r <= 1'b0;
            ready_out <= 1'b0;
            resp_valid_out <= 1'b0;
            resp_rdata_out <= 1'b0;
            init_done_out <= 1'b0;
        end else begin
            start_r <= 1'b0;
            resp_valid_out <= 1'b0;
            case (state_r)
                DSC_M_PAUSE: begin
                    timer_r <= timer_r + TW'(1);
                    if (timer_r >= TW'(PAUSE_CYCLES) - TW'(1)) begin
                        state_r <= DSC_M_INIT;
                        init_cnt_r <= '0;
                    end
                end
                DSC_M_INIT: begin
                    if (!seq_bus.busy && !start_r) begin
                        if (init_cnt_r == INIT_N) begin
                            state_r <= DSC_M_IDLE;
                            init_done_out <= 1'b1;
                            ready_out <= !low_power_sync_r;
                        end else begin
                            init_cnt_r <= init_cnt_r + 4'(1);
                            cmd_r <= DSC_CMD_REFRESH;
                            row_r <= refresh_row_r;
                            refresh_row_r <= refresh_row_r + ROW_W'(1);
                            start_r <= 1'b1;
                        end
                    end
                end
                DSC_M_IDLE: begin
                    if (idle_timer_r >= TW'(IDLE_LIMIT)) begin
                        state_r <= DSC_M_INIT;
                        init_cnt_r <= '0;
                        ready_out <= 1'b0;
                        init_done_out <= 1'b0;
                    end else if (refresh_due_r) begin
                        // Refresh wins over a waiting user request
                        cmd_r <= DSC_CMD_REFRESH;
                        row_r <= refresh_row_r;
                        refresh_row_r <= refresh_row_r + ROW_W'(1);
                        is_user_r <= 1'b0;
                        start_r <= 1'b1;
                        ready_out <= 1'b0;
                        state_r <= DSC_M_BUSY;
                    end else if (req_valid_in && ready_out) begin
                        cmd_r <= req_cmd_in;
                        row_r <= req_addr_in[ROW_W-1:0];
                        col_r <= req_addr_in[ADDR_W-1:ROW_W];
                        wdata_r <= req_wdata_in;
                        is_user_r <= 1'b1;
                        start_r <= 1'b1;
                        ready_out <= 1'b0;
                        state_r <= DSC_M_BUSY;
                    end else begin
                        ready_out <= !low_power_sync_r;
                    end
                end
                DSC_M_BUSY: begin
                    state_r <= DSC_M_WAIT;
                end
                DSC_M_WAIT: begin
                    if (seq_bus.done) begin
                        state_r <= DSC_M_IDLE;
                        if (is_user_r) begin
                            resp_valid_out <= 1'b1;
                            // Only read and read-modify-write data is meaningful
                            resp_rdata_out <= (cmd_r == DSC_CMD_READ || cmd_r == DSC_CMD_RMW) ?
                                              seq_bus.rdata : 1'b0;
                        end
                    end
                end
                default: state_r <= DSC_M_PAUSE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### dsc_ctrl_monitor.sv
// Purpose: Pin-level timing checks on the strobe-cycle controller
// Assumes: All strobes registered on core_clk_in
// Notes: Bound to dsc_ctrl; sees its ports only
`default_nettype none
module dsc_ctrl_monitor
    import dsc_pkg::*;
#(
    parameter int REFRESH_SPACING = 156,
    parameter int EXT_REFRESH_SPACING = 2500
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic init_done_out,
    input wire logic ras_n_out,
    input wire logic cas_n_out,
    input wire logic we_n_out,
    input wire logic [dsc_pkg::ROW_W-1:0] addr_out
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int GAP_MIN = CYCLE_CYC - 1;
    int gap_r;
    int falls_r;
    int we_low_r;

    // Saturate so a long standby cannot wrap the gap
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) gap_r <= 0;
        else if ($fell(ras_n_out)) gap_r <= 0;
        else if (gap_r < 1000000) gap_r <= gap_r + 1;
    end
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) falls_r <= 0;
        else if ($fell(ras_n_out) && falls_r < 15) falls_r <= falls_r + 1;
    end
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) we_low_r <= 0;
        else if (we_n_out) we_low_r <= 0;
        else if (we_low_r < 255) we_low_r <= we_low_r + 1;
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_init_count; $rose(init_done_out) |-> falls_r >= INIT_CYCLES; endproperty
    a_init_count: assert property (p_init_count) else $error("init done too early");
    property p_init_ras_only; !init_done_out |-> cas_n_out; endproperty
    a_init_ras_only: assert property (p_init_ras_only) else $error("column strobe during init");
    property p_cycle_gap; $fell(ras_n_out) |-> gap_r >= GAP_MIN; endproperty
    a_cycle_gap: assert property (p_cycle_gap) else $error("row strobe falls too close");
    property p_ras_after_cas; $fell(cas_n_out) |-> !ras_n_out ##1 !ras_n_out; endproperty
    a_ras_after_cas: assert property (p_ras_after_cas) else $error("row strobe released early");
    property p_col_hold; $fell(cas_n_out) |=> $stable(addr_out); endproperty
    a_col_hold: assert property (p_col_hold) else $error("column address dropped");
    property p_we_pulse; $rose(we_n_out) |-> we_low_r >= WP_CYC; endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe pulse short");
    property p_we_lead; $fell(we_n_out) |-> !ras_n_out && !$rose(cas_n_out); endproperty
    a_we_lead: assert property (p_we_lead) else $error("write strobe lead short");
    property p_we_at_cas; $fell(cas_n_out) |-> $stable(we_n_out); endproperty
    a_we_at_cas: assert property (p_we_at_cas) else $error("write strobe moves at column fall");
    property p_read_hold; $rose(cas_n_out) && $past(we_n_out) |-> we_n_out; endproperty
    a_read_hold: assert property (p_read_hold) else $error("read hold broken");
    property p_refresh_gap; init_done_out |-> gap_r <= EXT_REFRESH_SPACING + 16; endproperty
    a_refresh_gap: assert property (p_refresh_gap) else $error("refresh overdue");
endmodule

bind dsc_ctrl dsc_ctrl_monitor #(
    .REFRESH_SPACING(REFRESH_SPACING),
    .EXT_REFRESH_SPACING(EXT_REFRESH_SPACING)
) u_mon (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .init_done_out(init_done_out),
    .ras_n_out(ras_n_out),
    .cas_n_out(cas_n_out),
    .we_n_out(we_n_out),
    .addr_out(addr_out)
);
`default_nettype wire

// ### dsc_mem_model.sv
// Purpose: Behavioural 64K x 1 multiplexed-address memory
// Assumes: Strobes move only on controller clock edges
// Notes: Released output shows inverse of last value, never a held level
`default_nettype none
module dsc_mem_model (
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic [7:0] addr_in,
    input wire logic din_in,
    output logic dout_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cells [0:65535];
    logic [7:0] row_r;
    logic [15:0] cell_r;
    logic drive_r;
    logic last_r;

    initial begin
        for (int i = 0; i < 65536; i++) cells[i] = 1'b0;
        row_r = 8'h00;
        cell_r = 16'h0000;
        drive_r = 1'b0;
        last_r = 1'b0;
    end
    always @(negedge ras_n_in) row_r = addr_in;
    always @(negedge cas_n_in) begin
        cell_r = {addr_in, row_r};
        if (!we_n_in) begin
            cells[cell_r] = din_in;
        end else begin
            #20;
            last_r = cells[cell_r];
            drive_r = 1'b1;
        end
    end
    // Late write keeps the read value on the output
    always @(negedge we_n_in) if (!cas_n_in && !ras_n_in) cells[cell_r] = din_in;
    always @(posedge cas_n_in) #20 drive_r = 1'b0;
    assign dout_out = drive_r ? last_r : ~last_r;
endmodule
`default_nettype wire

// ### dsc_ctrl_tb.sv
// Purpose: Self-checking bench for the strobe-cycle controller
// Assumes: Memory model answers well inside one clock
// Notes: Short pause, extended refresh spacing and idle limit keep the run brief
`default_nettype none
module dsc_ctrl_tb;
    import dsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int EXT_SP = 500;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic req_valid_in = 1'b0;
    dsc_cmd_e req_cmd_in = DSC_CMD_READ;
    logic [15:0] req_addr_in = 16'h0000;
    logic req_wdata_in = 1'b0;
    logic low_power_in = 1'b0;
    logic ready_out, resp_valid_out, resp_rdata_out, init_done_out;
    logic ras_n_out, cas_n_out, we_n_out, din_out, dout_in;
    logic [7:0] addr_out;
    logic shadow [0:65535];
    int num_errors = 0;
    int checks = 0;
    int seed = 32'hfe1d;
    int cyc = 0;
    int falls = 0;
    int f0;
    logic [15:0] corners [4] = '{16'h0000, 16'hFFFF, 16'h00FF, 16'hFF00};

    dsc_ctrl #(.PAUSE_CYCLES(10), .REFRESH_SPACING(156), .EXT_REFRESH_SPACING(EXT_SP), .IDLE_LIMIT(2000)) u_dut (
        .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
        .req_cmd_in(req_cmd_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
        .low_power_in(low_power_in), .ready_out(ready_out), .resp_valid_out(resp_valid_out),
        .resp_rdata_out(resp_rdata_out), .init_done_out(init_done_out), .ras_n_out(ras_n_out),
        .cas_n_out(cas_n_out), .we_n_out(we_n_out), .addr_out(addr_out), .din_out(din_out),
        .dout_in(dout_in));
    dsc_mem_model u_mem (.ras_n_in(ras_n_out), .cas_n_in(cas_n_out), .we_n_in(we_n_out),
        .addr_in(addr_out), .din_in(din_out), .dout_out(dout_in));

    initial forever #50 core_clk_in = ~core_clk_in;
    always @(negedge ras_n_out) falls++;
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 12000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic expect_rd(input dsc_cmd_e c, input logic [15:0] a);
        return (c == DSC_CMD_READ || c == DSC_CMD_RMW) ? shadow[a] : 1'b0;
    endfunction

    // Request held until the response pulse; one outstanding at a time
    task automatic access(input dsc_cmd_e c, input logic [15:0] a, input logic w);
        logic exp;
        int n;
        exp = expect_rd(c, a);
        if (c == DSC_CMD_WRITE || c == DSC_CMD_RMW) shadow[a] = w;
        @(posedge core_clk_in);
        req_valid_in <= 1'b1;
        req_cmd_in <= c;
        req_addr_in <= a;
        req_wdata_in <= w;
        n = 0;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (resp_valid_out !== 1'b1 && n < 400);
        req_valid_in <= 1'b0;
        check(32'(resp_valid_out), 32'h1);
        check(32'(resp_rdata_out), 32'(exp));
    endtask

    task automatic wait_init();
        int n;
        n = 0;
        while (init_done_out !== 1'b1 && n < 300) begin
            @(posedge core_clk_in);
            n++;
        end
        check(32'(init_done_out), 32'h1);
        check(32'(falls >= INIT_CYCLES), 32'h1);
    endtask

    initial begin
        for (int i = 0; i < 65536; i++) shadow[i] = 1'b0;
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        wait_init();
        foreach (corners[i]) begin
            access(DSC_CMD_WRITE, corners[i], 1'b1);
            access(DSC_CMD_RMW, corners[i], 1'b0);
            access(DSC_CMD_READ, corners[i], 1'b0);
        end
        repeat (40) access(dsc_cmd_e'(2'($random(seed))), 16'($random(seed)) & 16'h0303, 1'($random(seed)));
        f0 = falls;
        repeat (1000) @(posedge core_clk_in);
        check(32'(falls - f0 >= 6), 32'h1);
        low_power_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        f0 = falls;
        repeat (1000) @(posedge core_clk_in);
        check(32'(ready_out), 32'h0);
        check(32'((falls - f0) inside {[1:3]}), 32'h1);
        low_power_in <= 1'b0;
        reset_n_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        falls = 0;
        wait_init();
        access(DSC_CMD_READ, 16'hFFFF, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
